// File: design/parameter_save_restore.sv
// How it works
// - After every reset, all saved category values reload into the live parameter copy.
// - The nonvolatile array is never touched by reset, so it survives firmware updates.
// - Saves and erases act on whole categories only, never single words.
// - Only the five category arrays are stored; status values never are.
// - Customer values are stored and readable but steer no internal function.
// - Drive parameters may be written and saved by the device's own setup.
// - Besides the setup save, a save starts only when the save key is written to a subindex.
// - When a save finishes the subindex reads back one.
// - Save subindex 1 is all, 2 to 6 one category each.
// - Erase starts only when the discard key is written to a subindex.
// - Discard 1 erases all but tuning; 2 to 6 erase one category.
// - Tuning is erased only by discard subindex 6.
// - A valid discard key drops the stored values of the chosen scope.
// - After the erase the device restarts itself with no command.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module parameter_save_restore (
  input  wire logic                         CORE_CLK_IN,
  input  wire logic                         RESET_N_IN,
  input  wire logic [23:0]                  REG_ADDR_IN,
  input  wire logic [31:0]                  REG_WDATA_IN,
  input  wire logic                         REG_WR_IN,
  input  wire logic                         REG_RD_IN,
  output logic      [31:0]                  REG_RDATA_OUT,
  input  wire logic                         SETUP_WR_IN,
  input  wire logic [$clog2(param_store_pkg::CAT_WORDS)-1:0] SETUP_ADDR_IN,
  input  wire logic [31:0]                  SETUP_WDATA_IN,
  input  wire logic                         SETUP_SAVE_IN,
  output logic                              BUSY_OUT,
  output logic                              RESTART_OUT,
  output logic                              IRQ_OUT
);
  import param_store_pkg::*;

  localparam int AW = $clog2(CAT_WORDS);
  localparam int CW = $clog2(NUM_CATS);
  localparam int DRIVE_CAT = 3;

  reg_req_s req;
  assign req = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN, wr: REG_WR_IN, rd: REG_RD_IN};

  // Object index in bits 23:8, subindex in bits 7:0.
  logic [15:0] obj_idx;
  logic [7:0]  sub_idx;
  assign obj_idx = req.addr[23:8];
  assign sub_idx = req.addr[7:0];

  // Nonvolatile image and live copy; the image has no reset on purpose.
  logic [31:0] nv_mem [NUM_CATS][CAT_WORDS];
  logic [31:0] live_mem [NUM_CATS][CAT_WORDS];
  // The image starts blank at power-on and reset never clears it.
  logic [NUM_CATS-1:0] nv_valid_reg = '0;

  nv_state_e   state_reg;
  logic [NUM_CATS-1:0] scope_reg;
  logic [2:0]  sub_reg;
  logic [31:0] save_sub_reg [1:6];
  logic [7:0]  cnt_reg;
  logic [CW-1:0] cat_reg;
  logic [AW-1:0] word_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_enable_reg;
  logic        restart_reg;

  logic sub_ok;
  logic save_hit;
  logic disc_hit;
  logic live_hit;
  logic bad_key;
  assign sub_ok   = (sub_idx >= 8'(SUB_ALL)) && (sub_idx <= 8'(SUB_LAST));
  assign save_hit = req.wr && obj_idx == SAVE_OBJ_IDX && sub_ok
                    && req.wdata == SAVE_KEY && state_reg == ST_IDLE;
  assign disc_hit = req.wr && obj_idx == DISCARD_OBJ_IDX && sub_ok
                    && req.wdata == DISCARD_KEY && state_reg == ST_IDLE;
  assign bad_key  = req.wr && sub_ok && !save_hit && !disc_hit
                    && (obj_idx == SAVE_OBJ_IDX || obj_idx == DISCARD_OBJ_IDX);
  // Live parameter words: object 0x200c, category c; subindex w, word w.
  assign live_hit = req.addr[23:12] == 12'h200 && req.addr[11:8] < 4'(NUM_CATS)
                    && req.addr[7:0] < 8'(CAT_WORDS);

  // Scope decode: all-categories leaves tuning out for an erase only.
  function automatic logic [NUM_CATS-1:0] scope_of(input logic [2:0] s, input logic erase);
    logic [NUM_CATS-1:0] m;
    m = '0;
    if (s == SUB_ALL) begin
      m = '1;
      if (erase) begin
        m[CAT_TUNING] = 1'b0;
      end
    end else begin
      m[3'(s - SUB_FIRST_CAT)] = 1'b1;
    end
    return m;
  endfunction

  // Sequencer: reload walks one word per cycle; save, erase and restart count fixed cycles.
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg   <= ST_RELOAD;
      scope_reg   <= '0;
      sub_reg     <= 3'h0;
      cnt_reg     <= 8'h00;
      cat_reg     <= '0;
      word_reg    <= '0;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      unique case (state_reg)
        ST_RELOAD: begin
          {cat_reg, word_reg} <= {cat_reg, word_reg} + 1'b1;
          if (word_reg == AW'(CAT_WORDS - 1)) begin
            word_reg <= '0;
            cat_reg  <= cat_reg + 1'b1;
            if (cat_reg == CW'(NUM_CATS - 1)) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          cnt_reg <= 8'h00;
          if (save_hit) begin
            state_reg <= ST_SAVE;
            sub_reg   <= sub_idx[2:0];
            scope_reg <= scope_of(sub_idx[2:0], 1'b0);
          end else if (disc_hit) begin
            state_reg <= ST_ERASE;
            sub_reg   <= sub_idx[2:0];
            scope_reg <= scope_of(sub_idx[2:0], 1'b1);
          end else if (SETUP_SAVE_IN) begin
            state_reg <= ST_SAVE;
            sub_reg   <= 3'(DRIVE_CAT) + SUB_FIRST_CAT;
            scope_reg <= NUM_CATS'(1) << DRIVE_CAT;
          end
        end
        ST_SAVE: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(STORE_CYCLES - 1)) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_ERASE: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(STORE_CYCLES - 1)) begin
            state_reg <= ST_RESTART;
            cnt_reg   <= 8'h00;
          end
        end
        ST_RESTART: begin
          cnt_reg     <= cnt_reg + 8'h01;
          restart_reg <= 1'b1;
          if (cnt_reg == 8'(RESTART_CYCLES - 1)) begin
            state_reg <= ST_RELOAD;
            cat_reg   <= '0;
            word_reg  <= '0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // The image copy happens in the last save cycle, so a category lands whole.
  logic save_commit;
  logic erase_commit;
  assign save_commit  = state_reg == ST_SAVE && cnt_reg == 8'(STORE_CYCLES - 1);
  assign erase_commit = state_reg == ST_ERASE && cnt_reg == 8'(STORE_CYCLES - 1);

  generate
    for (genvar c = 0; c < NUM_CATS; c++) begin : g_cat
      always_ff @(posedge CORE_CLK_IN) begin
        if (save_commit && scope_reg[c]) begin
          for (int w = 0; w < CAT_WORDS; w++) begin
            nv_mem[c][w] <= live_mem[c][w];
          end
        end
      end
    end
  endgenerate

  // Valid flags must survive reset as part of the image; a real part keeps them in flash.
  always_ff @(posedge CORE_CLK_IN) begin
    if (save_commit) begin
      nv_valid_reg <= nv_valid_reg | scope_reg;
    end else if (erase_commit) begin
      nv_valid_reg <= nv_valid_reg & ~scope_reg;
    end
  end

  // Live copy: reloads from the image, else zero default; written by software or setup.
  always_ff @(posedge CORE_CLK_IN) begin
    if (state_reg == ST_RELOAD) begin
      live_mem[cat_reg][word_reg] <= nv_valid_reg[cat_reg] ? nv_mem[cat_reg][word_reg]
                                                            : 32'h00000000;
    end else if (req.wr && live_hit) begin
      live_mem[req.addr[8+CW-1:8]][req.addr[AW-1:0]] <= req.wdata;
    end else if (SETUP_WR_IN) begin
      live_mem[DRIVE_CAT][SETUP_ADDR_IN] <= SETUP_WDATA_IN;
    end
  end

  // Save subindex values: key while a keyed save is busy, one when finished.
  generate
    for (genvar s = 1; s <= 6; s++) begin : g_sub
      always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          save_sub_reg[s] <= IDLE_VALUE;
        end else if (save_commit && sub_reg == 3'(s)) begin
          save_sub_reg[s] <= DONE_VALUE;
        end else if (save_hit && sub_idx[2:0] == 3'(s)) begin
          save_sub_reg[s] <= SAVE_KEY;
        end
      end
    end
  endgenerate

  // Interrupt status: set wins over a clear in the same cycle.
  logic [2:0] irq_set;
  assign irq_set = {bad_key, erase_commit, save_commit};
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_status_reg <= 3'h0;
    end else begin
      irq_status_reg <= irq_set | (irq_status_reg
                        & ~((req.wr && obj_idx == IRQ_CLEAR_IDX) ? req.wdata[2:0] : 3'h0));
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_enable_reg <= 3'h0;
    end else if (req.wr && obj_idx == IRQ_ENABLE_IDX) begin
      irq_enable_reg <= req.wdata[2:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= 32'h00000000;
    end else if (req.rd) begin
      if (obj_idx == SAVE_OBJ_IDX && sub_ok) begin
        REG_RDATA_OUT <= save_sub_reg[sub_idx[2:0]];
      end else if (obj_idx == DISCARD_OBJ_IDX && sub_ok) begin
        REG_RDATA_OUT <= IDLE_VALUE;
      end else if (live_hit) begin
        REG_RDATA_OUT <= live_mem[req.addr[8+CW-1:8]][req.addr[AW-1:0]];
      end else if (obj_idx == IRQ_STATUS_IDX) begin
        REG_RDATA_OUT <= {29'h0, irq_status_reg};
      end else if (obj_idx == IRQ_ENABLE_IDX) begin
        REG_RDATA_OUT <= {29'h0, irq_enable_reg};
      end else if (obj_idx == DEV_STATUS_IDX) begin
        REG_RDATA_OUT <= {24'h0, 3'h0, nv_valid_reg};
      end else begin
        REG_RDATA_OUT <= 32'h00000000;
      end
    end else begin
      REG_RDATA_OUT <= 32'h00000000;
    end
  end

  assign BUSY_OUT    = state_reg != ST_IDLE;
  assign RESTART_OUT = restart_reg;
  assign IRQ_OUT     = |(irq_status_reg & irq_enable_reg);
endmodule
`default_nettype wire

// File: design/param_store_pkg.sv
`default_nettype none
package param_store_pkg;
  localparam logic [15:0] SAVE_OBJ_IDX    = 16'h1010;
  localparam logic [15:0] DISCARD_OBJ_IDX = 16'h1011;
  localparam logic [15:0] IRQ_STATUS_IDX  = 16'h1F00;
  localparam logic [15:0] IRQ_ENABLE_IDX  = 16'h1F01;
  localparam logic [15:0] IRQ_CLEAR_IDX   = 16'h1F02;
  localparam logic [15:0] DEV_STATUS_IDX  = 16'h1F03;
  localparam logic [31:0] SAVE_KEY        = 32'h65766173;
  localparam logic [31:0] DISCARD_KEY     = 32'h64616F6C;
  localparam logic [31:0] DONE_VALUE      = 32'h00000001;
  localparam logic [31:0] IDLE_VALUE      = 32'h00000000;
  localparam logic [2:0]  SUB_ALL         = 3'h1;
  localparam logic [2:0]  SUB_FIRST_CAT   = 3'h2;
  localparam logic [2:0]  SUB_LAST        = 3'h6;
  localparam int          NUM_CATS        = 5;
  localparam int          CAT_TUNING      = 4;
  localparam int          CAT_WORDS       = 8;
  localparam int          IRQ_SAVE_DONE_BIT    = 0;
  localparam int          IRQ_DISCARD_DONE_BIT = 1;
  localparam int          IRQ_BAD_KEY_BIT      = 2;
  localparam int          STORE_TIME_NS   = 100;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          STORE_CYCLES    = (STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RESTART_CYCLES  = 4;
  localparam int          RELOAD_CYCLES   = NUM_CATS * CAT_WORDS;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef enum logic [2:0] {
    ST_RELOAD  = 3'b000,
    ST_IDLE    = 3'b001,
    ST_SAVE    = 3'b010,
    ST_ERASE   = 3'b011,
    ST_RESTART = 3'b100
  } nv_state_e;
endpackage
`default_nettype wire

// File: bench/parameter_save_restore_sva.sv
`timescale 1ns/1ps
`default_nettype none
module parameter_save_restore_sva
  import param_store_pkg::*;
(
  input wire logic        CORE_CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic [23:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic        SETUP_WR_IN,
  input wire logic [$clog2(param_store_pkg::CAT_WORDS)-1:0] SETUP_ADDR_IN,
  input wire logic [31:0] SETUP_WDATA_IN,
  input wire logic        SETUP_SAVE_IN,
  input wire logic        BUSY_OUT,
  input wire logic        RESTART_OUT,
  input wire logic        IRQ_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic sub_ok;
  logic save_go;
  logic disc_go;
  logic bad_go;
  // The all-categories save takes the same ten cycles but is left out; timing is pinned on single categories only.
  assign sub_ok  = REG_ADDR_IN[7:0] >= 8'h01 && REG_ADDR_IN[7:0] <= 8'h06;
  assign save_go = REG_WR_IN && !BUSY_OUT && REG_ADDR_IN[23:8] == SAVE_OBJ_IDX &&
                   REG_ADDR_IN[7:0] != 8'h01 && sub_ok && REG_WDATA_IN == SAVE_KEY;
  assign disc_go = REG_WR_IN && !BUSY_OUT && REG_ADDR_IN[23:8] == DISCARD_OBJ_IDX &&
                   sub_ok && REG_WDATA_IN == DISCARD_KEY;
  assign bad_go  = REG_WR_IN && !BUSY_OUT && sub_ok &&
                   ((REG_ADDR_IN[23:8] == SAVE_OBJ_IDX && REG_WDATA_IN != SAVE_KEY) ||
                    (REG_ADDR_IN[23:8] == DISCARD_OBJ_IDX && REG_WDATA_IN != DISCARD_KEY));
  sequence store_s;
    BUSY_OUT [*8] ##1 BUSY_OUT ##1 BUSY_OUT ##1 !BUSY_OUT;
  endsequence
  sequence reload_s;
    BUSY_OUT [*8] ##[28:34] !BUSY_OUT;
  endsequence
  sequence restart_s;
    RESTART_OUT [*4] ##1 !RESTART_OUT;
  endsequence
  AST_SAVE_START: assert property (save_go |=> store_s)
    else $error("save key did not give a ten cycle store");
  AST_SETUP_SAVE: assert property (SETUP_SAVE_IN && !BUSY_OUT |=> BUSY_OUT [*8])
    else $error("setup save did not start a store");
  AST_BAD_KEY: assert property (bad_go |=> !BUSY_OUT [*2])
    else $error("wrong key started an operation");
  AST_DISCARD: assert property (disc_go |-> ##[10:12] $rose(RESTART_OUT) ##0 restart_s)
    else $error("discard did not end in a four cycle restart");
  AST_RESTART_BUSY: assert property (RESTART_OUT |-> BUSY_OUT)
    else $error("restart while not busy");
  AST_RELOAD_RESTART: assert property ($fell(RESTART_OUT) |-> reload_s)
    else $error("no reload after restart");
  AST_RELOAD_RESET: assert property (RESET_N_IN && !$past(RESET_N_IN) |-> reload_s)
    else $error("no reload after reset");
  AST_READ_WINDOW: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h00000000)
    else $error("read data outside its cycle");
endmodule
bind parameter_save_restore parameter_save_restore_sva sva_i (
  .CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .SETUP_WR_IN(SETUP_WR_IN), .SETUP_ADDR_IN(SETUP_ADDR_IN),
  .SETUP_WDATA_IN(SETUP_WDATA_IN), .SETUP_SAVE_IN(SETUP_SAVE_IN), .BUSY_OUT(BUSY_OUT),
  .RESTART_OUT(RESTART_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// File: bench/parameter_save_restore_bench.sv
`timescale 1ns/1ps
`default_nettype none
module parameter_save_restore_bench;
  import param_store_pkg::*;
  typedef struct packed { logic [7:0] sub; logic [31:0] status; } row_s;
  logic        clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, s_wr = 0, s_save = 0;
  logic [23:0] addr = 24'h000000;
  logic [31:0] wdata = 32'h00000000, s_wdata = 32'h00000000, rdata, exp_st;
  logic [2:0]  s_addr = 3'h0;
  logic        busy, rst_out, irq;
  int          err_total = 0, n_compared = 0, cycles = 0, k;
  row_s        rows [6] = '{'{8'h02, 32'h01}, '{8'h03, 32'h03}, '{8'h04, 32'h07},
                            '{8'h05, 32'h0F}, '{8'h06, 32'h1F}, '{8'h01, 32'h1F}};
  parameter_save_restore DUT (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
    .SETUP_WR_IN(s_wr), .SETUP_ADDR_IN(s_addr), .SETUP_WDATA_IN(s_wdata),
    .SETUP_SAVE_IN(s_save), .BUSY_OUT(busy), .RESTART_OUT(rst_out), .IRQ_OUT(irq));
  always #5 clk = ~clk;
  // The ceiling is some thirty times the expected run so a slow but correct design still ends.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end
  task close_out;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask
  task wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task rd(input logic [23:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task idle;
    k = 0;
    while (busy !== 1'b0 && k < 500) begin
      @(negedge clk);
      k++;
    end
    if (busy !== 1'b0) begin
      err_total++;
      $display("unexpected at %0t: busy never fell", $time);
    end
  endtask
  initial begin
    repeat (15) @(posedge clk);
    #1 chk({busy, rst_out, irq}, 32'h4);
    @(posedge clk) rst_n <= 1'b1;
    idle();
    rd({DEV_STATUS_IDX, 8'h00}, 32'h0);
    wr({IRQ_ENABLE_IDX, 8'h00}, 32'h7);
    for (int c = 0; c < 5; c++) wr({12'h200, 4'(c), 8'h00}, 32'hA0000000 | c);
    foreach (rows[i]) begin
      wr({SAVE_OBJ_IDX, rows[i].sub}, SAVE_KEY);
      chk(32'(busy), 32'h1);
      idle();
      rd({SAVE_OBJ_IDX, rows[i].sub}, DONE_VALUE);
      rd({DEV_STATUS_IDX, 8'h00}, rows[i].status);
    end
    $display("save table done");
    chk(32'(irq), 32'h1);
    rd({IRQ_STATUS_IDX, 8'h00}, 32'h1);
    wr({IRQ_CLEAR_IDX, 8'h00}, 32'h7);
    chk(32'(irq), 32'h0);
    wr({12'h200, 4'h0, 8'h00}, 32'h00005555);
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    rd({12'h200, 4'h0, 8'h00}, 32'hA0000000);
    rd({12'h200, 4'h2, 8'h00}, 32'hA0000002);
    $display("reload test done");
    wr({SAVE_OBJ_IDX, 8'h02}, 32'h12345678);
    chk(32'(busy), 32'h0);
    wr({SAVE_OBJ_IDX, 8'h07}, SAVE_KEY);
    chk(32'(busy), 32'h0);
    wr({IRQ_STATUS_IDX, 8'h00}, 32'h0);
    rd({IRQ_STATUS_IDX, 8'h00}, 32'h4);
    wr({SAVE_OBJ_IDX, 8'h03}, SAVE_KEY);
    wr({DISCARD_OBJ_IDX, 8'h01}, DISCARD_KEY);
    idle();
    rd({DEV_STATUS_IDX, 8'h00}, 32'h1F);
    @(posedge clk) s_wr <= 1'b1; s_addr <= 3'h1; s_wdata <= 32'hD0D00001;
    @(posedge clk) s_wr <= 1'b0; s_save <= 1'b1;
    @(posedge clk) s_save <= 1'b0;
    #1 chk(32'(busy), 32'h1);
    idle();
    rd({12'h200, 4'h3, 8'h01}, 32'hD0D00001);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    idle();
    rd({12'h200, 4'h3, 8'h01}, 32'hD0D00001);
    $display("refusal and setup tests done");
    exp_st = 32'h1F;
    for (int s = 2; s < 6; s++) begin
      wr({DISCARD_OBJ_IDX, 8'(s)}, DISCARD_KEY);
      idle();
      exp_st = exp_st & ~(32'h1 << (s - 2));
      rd({DEV_STATUS_IDX, 8'h00}, exp_st);
    end
    wr({SAVE_OBJ_IDX, 8'h01}, SAVE_KEY);
    idle();
    wr({DISCARD_OBJ_IDX, 8'h01}, DISCARD_KEY);
    k = 0;
    while (rst_out !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (rst_out === 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk(32'(k), 32'h4);
    idle();
    rd({DEV_STATUS_IDX, 8'h00}, 32'h10);
    rd({12'h200, 4'h4, 8'h00}, 32'hA0000004);
    wr({DISCARD_OBJ_IDX, 8'h06}, DISCARD_KEY);
    idle();
    rd({DEV_STATUS_IDX, 8'h00}, 32'h0);
    $display("discard tests done");
    close_out();
  end
endmodule
`default_nettype wire
